// >>> logic/core_status_pkg.sv
/*
  core_status_pkg: constants, types and field layout shared by the status
  register block. Assumes a single 200 MHz clock and an AXI4-Lite bus.
*/
`default_nettype none
package core_status_pkg;
  // data-memory locations of the status register, one per bank (indices)
  localparam logic [8:0] STATUS_IDX_B0 = 9'h003;
  localparam logic [8:0] STATUS_IDX_B1 = 9'h083;
  localparam logic [8:0] STATUS_IDX_B2 = 9'h103;
  localparam logic [8:0] STATUS_IDX_B3 = 9'h183;
  // bank-independent low part of the location
  localparam logic [6:0] STATUS_IDX_LOW = 7'h03;
  localparam int         IDX_LOW_W      = 7;
  localparam int         IDX_W          = 9;
  // bus byte address = index * 4
  localparam int         AXI_ADDR_W     = 12;
  localparam int         BYTE_SHIFT     = 2;
  // field positions
  localparam int BIT_CARRY  = 0;
  localparam int BIT_NIBBLE = 1;
  localparam int BIT_ZERO   = 2;
  localparam int BIT_SLEEP  = 3;
  localparam int BIT_WDOG   = 4;
  localparam int BIT_BANKLO = 5;
  localparam int BIT_BANKHI = 6;
  localparam int BIT_INDIR  = 7;
  localparam int NIB_W      = 4;
  // reset value: banks 0, watchdog and sleep flags set, arithmetic flags 0
  localparam logic [7:0] STATUS_RESET = 8'h18;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_DECERR  = 2'h3;

  typedef enum logic [1:0] {
    ALU_NONE  = 2'b00,
    ALU_ADD   = 2'b01,
    ALU_SUB   = 2'b10,
    ALU_LOGIC = 2'b11
  } alu_op_t;

  // one write from the instruction datapath
  typedef struct packed {
    logic             en;
    logic [IDX_W-1:0] addr;
    logic [7:0]       data;
  } dp_write_t;

  // one ALU operation and which flags the instruction updates
  typedef struct packed {
    alu_op_t    op;
    logic [7:0] a;
    logic [7:0] b;
    logic [2:0] upd;  // {zero, nibble, carry}
  } alu_req_t;

  // reset-cause and sleep events, one-cycle pulses
  typedef struct packed {
    logic wdog_clear;
    logic sleep_exec;
    logic wdog_timeout;
  } cause_evt_t;
endpackage
`default_nettype wire

// >>> logic/core_status_unit.sv
/*
  core_status_unit: processor status register with ALU flag logic, bank
  select outputs and an AXI4-Lite slave. Assumes the datapath presents at
  most one instruction write per cycle, synchronous to aclk.
*/
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - one register holds ALU flags, reset-cause flags and bank bits
// - register answers at 03h, 83h, 103h and 183h in every bank
// - status accepts instruction results like any data register
// - flag-updating instruction to status: flags come from ALU, not data
// - watchdog and sleep flags ignore writes; only cause logic changes them
// - clear to status clears bank bits, sets zero, keeps the rest
// - subtraction drives carry and nibble carry as inverted borrow
// - nibble carry set on carry out of bit 3, inverted on subtract
module core_status_unit
  import core_status_pkg::*;
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire dp_write_t             dp_wr,
  input  wire alu_req_t              alu_req,
  input  wire cause_evt_t            cause_evt,
  output logic [7:0]                 status_q,
  output logic [7:0]                 alu_result,
  output logic [1:0]                 direct_bank,
  output logic                       indirect_bank_bit,
  input  wire logic [AXI_ADDR_W-1:0] s_awaddr,
  input  wire logic                  s_awvalid,
  output logic                       s_awready,
  input  wire logic [31:0]           s_wdata,
  input  wire logic [3:0]            s_wstrb,
  input  wire logic                  s_wvalid,
  output logic                       s_wready,
  output logic [1:0]                 s_bresp,
  output logic                       s_bvalid,
  input  wire logic                  s_bready,
  input  wire logic [AXI_ADDR_W-1:0] s_araddr,
  input  wire logic                  s_arvalid,
  output logic                       s_arready,
  output logic [31:0]                s_rdata,
  output logic [1:0]                 s_rresp,
  output logic                       s_rvalid,
  input  wire logic                  s_rready
);

  // any bank's copy of the status location
  function automatic logic is_status(input logic [IDX_W-1:0] idx);
    is_status = (idx[IDX_LOW_W-1:0] == STATUS_IDX_LOW);
  endfunction

  logic [7:0]            st_r, st_nxt;
  logic [7:0]            res_r;
  logic [IDX_W-1:0]      awidx_r;
  logic [7:0]            wdat_r;
  logic                  wlane_r;
  logic                  aw_have_r, w_have_r;
  logic                  bvalid_r, rvalid_r;
  logic [1:0]            bresp_r, rresp_r;
  logic [7:0]            rdata_r;

  // ALU: subtraction adds the two's complement of b
  wire                   is_sub    = (alu_req.op == ALU_SUB);
  wire [7:0]             b_eff     = is_sub ? ~alu_req.b : alu_req.b;
  wire [8:0]             sum9      = {1'b0, alu_req.a} + {1'b0, b_eff} + {8'h00, is_sub};
  wire [NIB_W:0]         nib_sum   = {1'b0, alu_req.a[NIB_W-1:0]} + {1'b0, b_eff[NIB_W-1:0]}
                                     + {4'h0, is_sub};
  wire [7:0]             alu_out   = (alu_req.op == ALU_LOGIC) ? alu_req.b : sum9[7:0];
  wire                   arith     = (alu_req.op == ALU_ADD) || is_sub;
  wire                   f_zero    = (alu_out == 8'h00);
  wire                   f_carry   = sum9[8];
  wire                   f_nibble  = nib_sum[NIB_W];
  wire [2:0]             alu_flags = {f_zero, f_nibble, f_carry};
  wire [2:0]             upd_eff   = (alu_req.op == ALU_NONE) ? 3'h0
                                   : (arith ? alu_req.upd : (alu_req.upd & 3'h4));

  // write sources: datapath first, bus write waits for an idle datapath
  wire                   dp_hit    = dp_wr.en && is_status(dp_wr.addr);
  wire                   aw_map    = is_status(awidx_r);
  wire                   bus_go    = aw_have_r && w_have_r && !bvalid_r && !dp_wr.en;
  wire                   bus_hit   = bus_go && aw_map && wlane_r;
  wire                   any_wr    = dp_hit || bus_hit;
  wire [7:0]             wr_val    = dp_hit ? dp_wr.data : wdat_r;
  // a flag-updating instruction locks all three flag bits against its data
  wire                   flag_wr   = bus_hit || (dp_hit && (upd_eff == 3'h0));

  // next flag bits: ALU result beats written data
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_flag
      assign st_nxt[g] = upd_eff[g] ? alu_flags[g]
                       : (flag_wr ? wr_val[g] : st_r[g]);
    end
  endgenerate

  // reset-cause flags: writes never reach them
  assign st_nxt[BIT_WDOG]  = cause_evt.wdog_timeout ? 1'b0
                           : ((cause_evt.wdog_clear || cause_evt.sleep_exec) ? 1'b1
                           : st_r[BIT_WDOG]);
  assign st_nxt[BIT_SLEEP] = cause_evt.sleep_exec ? 1'b0
                           : (cause_evt.wdog_clear ? 1'b1 : st_r[BIT_SLEEP]);
  // bank bits follow any write, so a clear zeroes them
  assign st_nxt[BIT_INDIR:BIT_BANKLO] = any_wr ? wr_val[BIT_INDIR:BIT_BANKLO]
                                      : st_r[BIT_INDIR:BIT_BANKLO];

  // status and ALU result registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r  <= STATUS_RESET;
      res_r <= 8'h00;
    end else begin
      st_r  <= st_nxt;
      res_r <= alu_out;
    end
  end

  assign status_q          = st_r;
  assign alu_result        = res_r;
  assign direct_bank       = st_r[BIT_BANKHI:BIT_BANKLO];
  assign indirect_bank_bit = st_r[BIT_INDIR];

  // bus write: capture address and data in either order
  assign s_awready = !aw_have_r;
  assign s_wready  = !w_have_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      awidx_r   <= '0;
      wdat_r    <= 8'h00;
      wlane_r   <= 1'b0;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_have_r <= 1'b1;
        awidx_r   <= s_awaddr[BYTE_SHIFT +: IDX_W];
      end else if (bus_go) begin
        aw_have_r <= 1'b0;
      end
      if (s_wvalid && s_wready) begin
        w_have_r <= 1'b1;
        wdat_r   <= s_wdata[7:0];
        wlane_r  <= s_wstrb[0];
      end else if (bus_go) begin
        w_have_r <= 1'b0;
      end
    end
  end

  // write response: decode error off the map
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else if (bus_go) begin
      bvalid_r <= 1'b1;
      bresp_r  <= aw_map ? RESP_OKAY : RESP_DECERR;
    end else if (s_bready) begin
      bvalid_r <= 1'b0;
    end
  end
  assign s_bvalid = bvalid_r;
  assign s_bresp  = bresp_r;

  // read channel: one cycle answer
  wire [IDX_W-1:0] aridx  = s_araddr[BYTE_SHIFT +: IDX_W];
  wire             ar_map = is_status(aridx);
  assign s_arready = !rvalid_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 8'h00;
      rresp_r  <= RESP_OKAY;
    end else if (s_arvalid && s_arready) begin
      rvalid_r <= 1'b1;
      rdata_r  <= ar_map ? st_r : 8'h00;
      rresp_r  <= ar_map ? RESP_OKAY : RESP_DECERR;
    end else if (s_rready) begin
      rvalid_r <= 1'b0;
    end
  end
  assign s_rvalid = rvalid_r;
  assign s_rresp  = rresp_r;
  assign s_rdata  = {24'h000000, rdata_r};

  // checks
  property p_flag_from_alu;
    @(posedge aclk) disable iff (!aresetn)
    (dp_hit && alu_req.op == ALU_ADD && alu_req.upd == 3'h7) |=> (st_r[2:0] == $past(alu_flags));
  endproperty
  a_flag_from_alu: assert property (p_flag_from_alu) else $error("flags not from alu");

  property p_cause_readonly;
    @(posedge aclk) disable iff (!aresetn)
    (any_wr && cause_evt == 3'h0) |=> (st_r[BIT_WDOG:BIT_SLEEP] == $past(st_r[BIT_WDOG:BIT_SLEEP]));
  endproperty
  a_cause_readonly: assert property (p_cause_readonly) else $error("cause flag written");

  property p_clear_status;
    @(posedge aclk) disable iff (!aresetn)
    (dp_hit && dp_wr.data == 8'h00 && alu_req.op == ALU_LOGIC && alu_req.b == 8'h00
     && alu_req.upd == 3'h4 && cause_evt == 3'h0)
    |=> (st_r[7:5] == 3'h0 && st_r[BIT_ZERO] && st_r[4:3] == $past(st_r[4:3])
         && st_r[1:0] == $past(st_r[1:0]));
  endproperty
  a_clear_status: assert property (p_clear_status) else $error("clear result wrong");

  property p_write_any_bank;
    @(posedge aclk) disable iff (!aresetn)
    (dp_wr.en && dp_wr.addr == STATUS_IDX_B3 && alu_req.op == ALU_NONE)
    |=> (st_r[7:5] == $past(dp_wr.data[7:5]) && st_r[2:0] == $past(dp_wr.data[2:0]));
  endproperty
  a_write_any_bank: assert property (p_write_any_bank) else $error("bank 3 write lost");

  property p_sub_borrow;
    @(posedge aclk) disable iff (!aresetn)
    (alu_req.op == ALU_SUB && alu_req.upd == 3'h7 && !dp_hit)
    |=> (st_r[BIT_CARRY] == ($past(alu_req.a) >= $past(alu_req.b))
         && st_r[BIT_NIBBLE] == ($past(alu_req.a[3:0]) >= $past(alu_req.b[3:0])));
  endproperty
  a_sub_borrow: assert property (p_sub_borrow) else $error("borrow polarity wrong");

  property p_nibble_add;
    @(posedge aclk) disable iff (!aresetn)
    (alu_req.op == ALU_ADD && alu_req.upd[1] && !dp_hit)
    |=> st_r[BIT_NIBBLE] == (({1'b0, $past(alu_req.a[3:0])} + {1'b0, $past(alu_req.b[3:0])}) > 5'h0f);
  endproperty
  a_nibble_add: assert property (p_nibble_add) else $error("nibble carry wrong");

  property p_zero_carry;
    @(posedge aclk) disable iff (!aresetn)
    (alu_req.op == ALU_ADD && alu_req.upd == 3'h7 && !dp_hit)
    |=> (st_r[BIT_ZERO] == (res_r == 8'h00)
         && st_r[BIT_CARRY] == (({1'b0, $past(alu_req.a)} + {1'b0, $past(alu_req.b)}) > 9'h0ff));
  endproperty
  a_zero_carry: assert property (p_zero_carry) else $error("zero or carry wrong");

  property p_bank_out;
    @(posedge aclk) disable iff (!aresetn)
    any_wr |=> (direct_bank == $past(wr_val[BIT_BANKHI:BIT_BANKLO])
                && indirect_bank_bit == $past(wr_val[BIT_INDIR]));
  endproperty
  a_bank_out: assert property (p_bank_out) else $error("bank output mismatch");

  property p_read_status;
    @(posedge aclk) disable iff (!aresetn)
    (s_arvalid && s_arready && ar_map) |=> (s_rvalid && s_rdata[7:0] == $past(st_r)
                                            && s_rresp == RESP_OKAY);
  endproperty
  a_read_status: assert property (p_read_status) else $error("status read wrong");

  c_bus_write: cover property (@(posedge aclk) disable iff (!aresetn) bus_hit);
  c_sleep:     cover property (@(posedge aclk) disable iff (!aresetn) cause_evt.sleep_exec);
  c_sub_flags: cover property (@(posedge aclk) disable iff (!aresetn)
                               dp_hit && alu_req.op == ALU_SUB);

endmodule // core_status_unit
`default_nettype wire

// >>> sim/dp_model.sv
/* dp_model: stand-in for the instruction datapath and ALU feeding the
   status block. Assumes the bench calls exec once per instruction. */
`timescale 1ns/1ps
`default_nettype none
module dp_model
  import core_status_pkg::*;
(
  input  wire logic aclk,
  output dp_write_t  dp_wr,
  output alu_req_t   alu_req,
  output cause_evt_t cause_evt
);
  initial begin
    dp_wr     = '0;
    alu_req   = '0;
    cause_evt = '0;
  end
  // one instruction for one cycle, issued right after the edge
  task automatic exec(input dp_write_t w, input alu_req_t r, input cause_evt_t e);
    @(posedge aclk);
    dp_wr     <= w;
    alu_req   <= r;
    cause_evt <= e;
  endtask
  // idle: no write, operands scrambled so stale values never look valid
  task automatic idle();
    @(posedge aclk);
    dp_wr     <= '{en: 1'b0, addr: ~dp_wr.addr, data: ~dp_wr.data};
    alu_req   <= '{op: ALU_NONE, a: ~alu_req.a, b: ~alu_req.b, upd: 3'h0};
    cause_evt <= '0;
  endtask
endmodule // dp_model
`default_nettype wire

// >>> sim/cpu_status_register_tb.sv
/* cpu_status_register_tb: self-checking bench for the status block.
   Assumes dp_model on the datapath side and an AXI4-Lite master here. */
`timescale 1ns/1ps
`default_nettype none
module cpu_status_register_tb
  import core_status_pkg::*;
;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, seen = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, ibank;
  logic [1:0]  bresp, rresp, dbank;
  logic [31:0] rdata;
  logic [7:0]  status_q, alu_result, st;
  dp_write_t   dp_wr;
  alu_req_t    alu_req;
  cause_evt_t  cause_evt;
  logic [16:0] q_st[$];
  logic [33:0] q_rd[$];
  logic [1:0]  q_b[$];
  integer      seed = 32'heeb1ab27;
  int          fails = 0;
  int          tests_run = 0;

  // 200 MHz clock
  always #2.5 aclk = ~aclk;

  core_status_unit i_dut (.aclk(aclk), .aresetn(aresetn), .dp_wr(dp_wr), .alu_req(alu_req),
    .cause_evt(cause_evt), .status_q(status_q), .alu_result(alu_result),
    .direct_bank(dbank), .indirect_bank_bit(ibank), .s_awaddr(awaddr), .s_awvalid(awvalid),
    .s_awready(awready), .s_wdata(wdata), .s_wstrb(wstrb), .s_wvalid(wvalid),
    .s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
    .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready), .s_rdata(rdata),
    .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready));
  dp_model i_dp (.aclk(aclk), .dp_wr(dp_wr), .alu_req(alu_req), .cause_evt(cause_evt));

  // count a comparison, report a mismatch
  task automatic report(input logic [33:0] got, input logic [33:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_st(input logic [16:0] e);
    report({15'h0000, e[16] ? alu_result : e[15:8], status_q, dbank, ibank},
           {15'h0000, e[15:8], e[7:0], e[6:5], e[7]});
  endtask
  task automatic cmp_rd(input logic [33:0] e);
    report({rresp, rdata}, e);
  endtask
  task automatic cmp_b(input logic [1:0] e);
    report({32'h0, bresp}, {32'h0, e});
  endtask

  // watcher: oldest expectation of each kind against what the block shows
  always @(posedge aclk) begin
    if (seen) cmp_st(q_st.pop_front());
    if (rvalid && rready) cmp_rd(q_rd.pop_front());
    if (bvalid && bready) cmp_b(q_b.pop_front());
    seen = dp_wr.en || alu_req.op != ALU_NONE || cause_evt != '0;
  end

  // one instruction plus its expected status and result
  task automatic dp(input logic [8:0] ad, input logic [7:0] d, input alu_op_t op,
                    input logic [7:0] a, input logic [7:0] b, input logic [2:0] upd,
                    input cause_evt_t e);
    logic [7:0] bb;
    logic [8:0] s;
    logic [4:0] h;
    bb = (op == ALU_SUB) ? ~b : b;
    s = {1'b0, a} + {1'b0, bb} + {8'h00, op == ALU_SUB};
    h = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, op == ALU_SUB};
    if (op == ALU_LOGIC) s = {1'b0, b};
    if (ad[6:0] == STATUS_IDX_LOW) st = {d[7:5], st[4:3], (upd == 3'h0) ? d[2:0] : st[2:0]};
    st[2:0] = (st[2:0] & ~upd) | ({s[7:0] == 8'h00, h[4], s[8]} & upd);
    if (e.wdog_clear) st[4:3] = 2'b11;
    if (e.sleep_exec) st[4:3] = 2'b10;
    if (e.wdog_timeout) st[4] = 1'b0;
    q_st.push_back({op != ALU_NONE, s[7:0], st});
    i_dp.exec('{en: 1'b1, addr: ad, data: d}, '{op: op, a: a, b: b, upd: upd}, e);
  endtask

  // bus write; the shadow follows an accepted low-byte write
  task automatic wr(input logic [11:0] ad, input logic [7:0] d, input logic [3:0] sb,
                    input logic [1:0] rsp);
    logic dn;
    dn = 1'b0;
    q_b.push_back(rsp);
    if (rsp == RESP_OKAY && sb[0]) st = {d[7:5], st[4:3], d[2:0]};
    @(posedge aclk);
    awaddr <= ad;
    wdata <= {24'($random(seed)), d};
    wstrb <= sb;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 50 && !dn; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        bready <= 1'b0;
        dn = 1'b1;
      end
    end
    if (!dn) fails++;
  endtask

  // bus read with its expected {resp, data}
  task automatic rd(input logic [11:0] ad, input logic [33:0] e);
    logic dn;
    dn = 1'b0;
    q_rd.push_back(e);
    @(posedge aclk);
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 50 && !dn; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        rready <= 1'b0;
        dn = 1'b1;
      end
    end
    if (!dn) fails++;
  endtask

  task automatic tally_and_finish();
    $display("tests_run=%0d fails=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // main sequence
  initial begin
    alu_op_t op;
    logic [7:0] ra;
    logic [7:0] rb;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    st = STATUS_RESET;
    for (int k = 0; k < 4; k++) rd({1'b0, k[1:0], 9'h00c}, {RESP_OKAY, 24'h0, st});
    rd(12'h010, {RESP_DECERR, 32'h0});
    wr(12'h010, 8'h00, 4'hf, RESP_DECERR);
    wr(12'h00c, 8'hff, 4'h1, RESP_OKAY);
    wr(12'h20c, 8'h00, 4'he, RESP_OKAY);
    rd(12'h40c, {RESP_OKAY, 24'h0, st});
    wr(12'h60c, 8'h00, 4'hf, RESP_OKAY);
    rd(12'h00c, {RESP_OKAY, 24'h0, st});
    for (int k = 0; k < 4; k++) dp({k[1:0], 7'h03}, 8'($random(seed)), ALU_NONE, 8'h00, 8'h00, 3'h0, '0);
    dp(9'h003, 8'he3, ALU_NONE, 8'h00, 8'h00, 3'h0, '0);
    dp(9'h103, 8'h00, ALU_LOGIC, 8'h5a, 8'h00, 3'h4, '0);
    for (int k = 0; k < 48; k++) begin
      op = (k % 3 == 0) ? ALU_ADD : (k % 3 == 1) ? ALU_SUB : ALU_LOGIC;
      ra = (k < 6) ? 8'h80 : 8'($random(seed));
      rb = (k < 6) ? 8'h80 : 8'($random(seed));
      dp((k % 5 == 0) ? 9'h183 : 9'h020, 8'($random(seed)), op, ra, rb, (op == ALU_LOGIC) ? 3'h4 : 3'h7, '0);
    end
    for (int k = 1; k < 6; k++) dp(9'h020, 8'h00, ALU_NONE, 8'h00, 8'h00, 3'h0, cause_evt_t'(k[2:0]));
    i_dp.idle();
    wr(12'h40c, 8'hff, 4'hf, RESP_OKAY);
    rd(12'h60c, {RESP_OKAY, 24'h0, st});
    // reset again mid-run: flags and bank bits return to their reset value
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    st = STATUS_RESET;
    rd(12'h20c, {RESP_OKAY, 24'h0, st});
    repeat (4) @(posedge aclk);
    tally_and_finish();
  end

  // hang guard, far beyond the roughly 125 cycles the run needs
  initial begin
    #20000;
    fails++;
    tally_and_finish();
  end
endmodule // cpu_status_register_tb
`default_nettype wire
